// >>> rtl/dacl_host.sv
// host controller writing 12-bit words into the double-buffered dac latch
// Function
// - chip select and strobes are active low
// - all low: every latch transparent
// - twos complement host inverts msb
// - left-justified bytes: high eight, low nibble up
// - right-justified bytes: low eight, high nibble low
// - left scheme: low nibble first, then high
// - right scheme: low byte first, then high
// - wide bus keeps data stable while selected
`include "dacl_regs.svh"
module dacl_host (
    input wire logic clk_sys,
    input wire logic rst_n,
    input dacl_pkg::dacl_mode_type mode,
    input dacl_pkg::dacl_code_type coding,
    input wire logic req_valid,
    input wire logic [11:0] req_word,
    output logic req_ready,
    output logic req_done,
    output logic chip_select_n,
    output logic low_nibble_strobe_n,
    output logic mid_nibble_strobe_n,
    output logic high_nibble_strobe_n,
    output logic output_rank_load_n,
    output logic [11:0] data_word_in
);
    import dacl_pkg::*;

    typedef enum logic [2:0] {
        DACL_IDLE, DACL_STEP1, DACL_WAIT1, DACL_STEP2, DACL_WAIT2, DACL_STEP3, DACL_WAIT3
    } dacl_state_type;

    dacl_state_type state;
    dacl_mode_type mode_q;
    logic [11:0] word;
    logic start;
    logic [4:0] ctl_n;
    logic [11:0] bus_word;
    logic busy;
    logic done;
    logic cs_pin;
    logic [3:0] addr_pin;
    logic [11:0] data_pin;

    // control image {select, rank, high, mid, low}, all active low
    function automatic logic [4:0] dacl_ctl(input logic [3:0] open_mask);
        dacl_ctl = {1'b0, ~open_mask};
    endfunction

    // twos complement words enter the device as offset binary
    function automatic logic [11:0] dacl_code(input logic [11:0] w, input dacl_code_type c);
        dacl_code = (c == DACL_CODE_TWOS) ? {~w[`DACL_MSB], w[10:0]} : w;
    endfunction

    // sequencing of the latch writes for each bus width
    always_ff @(posedge clk_sys) begin
        req_done <= 1'b0;
        if (!rst_n) begin
            state <= DACL_IDLE;
            mode_q <= DACL_MODE_WIDE;
            word <= 12'h000;
        end else begin
            case (state)
                DACL_IDLE: begin
                    if (req_valid) begin
                        mode_q <= mode;
                        word <= dacl_code(req_word, coding);
                        state <= DACL_STEP1;
                    end
                end
                DACL_STEP1: state <= DACL_WAIT1;
                DACL_WAIT1: begin
                    if (done) begin
                        state <= (mode_q == DACL_MODE_WIDE) ? DACL_IDLE : DACL_STEP2;
                        req_done <= (mode_q == DACL_MODE_WIDE);
                    end
                end
                DACL_STEP2: state <= DACL_WAIT2;
                DACL_WAIT2: begin
                    if (done) begin
                        state <= (mode_q == DACL_MODE_NIBBLE) ? DACL_STEP3 : DACL_IDLE;
                        req_done <= (mode_q != DACL_MODE_NIBBLE);
                    end
                end
                DACL_STEP3: state <= DACL_WAIT3;
                DACL_WAIT3: begin
                    if (done) begin
                        state <= DACL_IDLE;
                        req_done <= 1'b1;
                    end
                end
                default: state <= DACL_IDLE;
            endcase
        end
    end

    // what each step drives; open latches as mask {rank, high, mid, low}
    always_comb begin
        start = (state == DACL_STEP1) || (state == DACL_STEP2) || (state == DACL_STEP3);
        ctl_n = 5'h1F;
        bus_word = 12'h000; // undriven lines sit at zero
        case (mode_q)
            DACL_MODE_WIDE: begin
                ctl_n = dacl_ctl(4'hF);
                bus_word = word; // held by the strobe engine
            end
            DACL_MODE_NIBBLE: begin
                if (state == DACL_STEP1) begin
                    ctl_n = dacl_ctl(4'h1);
                    bus_word = {8'h00, word[3:0]};
                end else if (state == DACL_STEP2) begin
                    ctl_n = dacl_ctl(4'h2);
                    bus_word = {4'h0, word[7:4], 4'h0};
                end else begin
                    ctl_n = dacl_ctl(4'hC);
                    bus_word = {word[11:8], 8'h00};
                end
            end
            DACL_MODE_LEFT_BYTE: begin
                if (state == DACL_STEP1) begin
                    ctl_n = dacl_ctl(4'h1); // low nibble first
                    bus_word = {8'h00, word[3:0]};
                end else begin
                    ctl_n = dacl_ctl(4'hE);
                    bus_word = {word[11:4], 4'h0};
                end
            end
            default: begin
                if (state == DACL_STEP1) begin
                    ctl_n = dacl_ctl(4'h3); // low byte first
                    bus_word = {4'h0, word[7:0]};
                end else begin
                    ctl_n = dacl_ctl(4'hC);
                    bus_word = {word[11:8], 8'h00};
                end
            end
        endcase
    end

    dacl_strobe u_strobe (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .start(start),
        .ctl_n(ctl_n),
        .data(bus_word),
        .busy(busy),
        .done(done),
        .chip_select_n(cs_pin),
        .addr_n(addr_pin),
        .bus_data(data_pin)
    );

    // pins retimed once more so every output is a flip-flop; the release of
    // the strobe captures the data in the device, so data stays at least three cycles past it
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            chip_select_n <= 1'b1;
            low_nibble_strobe_n <= 1'b1;
            mid_nibble_strobe_n <= 1'b1;
            high_nibble_strobe_n <= 1'b1;
            output_rank_load_n <= 1'b1;
            data_word_in <= 12'h000;
        end else begin
            chip_select_n <= cs_pin;
            low_nibble_strobe_n <= addr_pin[0];
            mid_nibble_strobe_n <= addr_pin[1];
            high_nibble_strobe_n <= addr_pin[2];
            output_rank_load_n <= addr_pin[3]; // four latches, four enables
            data_word_in <= data_pin;
        end
    end

    // ready only when idle and nothing pending in the strobe engine
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            req_ready <= 1'b0;
        end else begin
            req_ready <= (state == DACL_IDLE) && !req_valid && !busy;
        end
    end
endmodule

// >>> rtl/dacl_pkg.sv
// types shared by the dac latch host controller
package dacl_pkg;
    typedef enum logic [1:0] {
        DACL_MODE_WIDE,
        DACL_MODE_NIBBLE,
        DACL_MODE_LEFT_BYTE,
        DACL_MODE_RIGHT_BYTE
    } dacl_mode_type;
    typedef enum logic {
        DACL_CODE_BINARY,
        DACL_CODE_TWOS
    } dacl_code_type;
endpackage

// >>> rtl/dacl_regs.svh
// timing counts and field positions for the dac latch host controller
`ifndef DACL_REGS_SVH
`define DACL_REGS_SVH
`define DACL_STROBE_NS 100
`define DACL_CLK_NS 50
`define DACL_STROBE_CYC ((`DACL_STROBE_NS + `DACL_CLK_NS - 1) / `DACL_CLK_NS)
`define DACL_SETUP_CYC 1
`define DACL_HOLD_CYC 1
`define DACL_MSB 11
`define DACL_LOW_LSB 0
`define DACL_MID_LSB 4
`define DACL_HIGH_LSB 8
`endif

// >>> rtl/dacl_strobe.sv
// one bus write cycle: setup, strobe low, hold, with a registered pin image
`include "dacl_regs.svh"
module dacl_strobe (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic start,
    input wire logic [4:0] ctl_n,
    input wire logic [11:0] data,
    output logic busy,
    output logic done,
    output logic chip_select_n,
    output logic [3:0] addr_n,
    output logic [11:0] bus_data
);
    typedef enum logic [1:0] {DACL_IDLE, DACL_SETUP, DACL_LOW, DACL_HOLD} dacl_phase_type;
    dacl_phase_type phase;
    logic [3:0] cnt;
    logic [4:0] ctl_hold;

    // phase sequencing; data is held stable over the whole low time
    always_ff @(posedge clk_sys) begin
        done <= 1'b0;
        if (!rst_n) begin
            phase <= DACL_IDLE;
            cnt <= 4'h0;
            ctl_hold <= 5'h1F;
            bus_data <= 12'h000;
        end else begin
            case (phase)
                DACL_IDLE: begin
                    if (start) begin
                        ctl_hold <= ctl_n;
                        bus_data <= data;
                        cnt <= 4'(`DACL_SETUP_CYC);
                        phase <= DACL_SETUP;
                    end
                end
                DACL_SETUP: begin
                    if (cnt <= 4'h1) begin
                        cnt <= 4'(`DACL_STROBE_CYC);
                        phase <= DACL_LOW;
                    end else begin
                        cnt <= cnt - 4'h1;
                    end
                end
                DACL_LOW: begin
                    if (cnt <= 4'h1) begin
                        cnt <= 4'(`DACL_HOLD_CYC);
                        phase <= DACL_HOLD;
                    end else begin
                        cnt <= cnt - 4'h1;
                    end
                end
                DACL_HOLD: begin
                    if (cnt <= 4'h1) begin
                        phase <= DACL_IDLE;
                        done <= 1'b1;
                    end else begin
                        cnt <= cnt - 4'h1;
                    end
                end
                default: phase <= DACL_IDLE;
            endcase
        end
    end

    // strobes low only during the low phase; release latches the data
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            chip_select_n <= 1'b1;
            addr_n <= 4'hF;
        end else if (phase == DACL_SETUP && cnt <= 4'h1) begin
            chip_select_n <= ctl_hold[4];
            addr_n <= ctl_hold[3:0];
        end else if (phase == DACL_LOW && cnt <= 4'h1) begin
            chip_select_n <= 1'b1;
            addr_n <= 4'hF;
        end
    end

    assign busy = (phase != DACL_IDLE);
endmodule

// >>> verification/dacl_device_model.sv
// behavioural model of the double-buffered dac input latches
module dacl_device_model (
    input wire logic chip_select_n,
    input wire logic low_nibble_strobe_n,
    input wire logic mid_nibble_strobe_n,
    input wire logic high_nibble_strobe_n,
    input wire logic output_rank_load_n,
    input wire logic [11:0] data_word_in,
    output logic [11:0] first_rank,
    output logic [11:0] dac_code
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] open_n;
    logic [11:0] data_seen;
    // three nibble latches plus the output rank; power-up contents taken as zero
    initial first_rank = 12'h000;
    initial dac_code = 12'h000;
    // active-low enables, each gated by select
    assign open_n = {output_rank_load_n, high_nibble_strobe_n, mid_nibble_strobe_n,
        low_nibble_strobe_n} | {4{chip_select_n}};
    // floating or unknown data lines read as zero, like open device inputs
    always @* begin
        for (int i = 0; i < 12; i++) begin
            data_seen[i] = (data_word_in[i] === 1'b1);
        end
    end
    // level latches: transparent while open, each holds when its own strobe or select rises
    always @* begin
        if (!open_n[0]) first_rank[3:0] = data_seen[3:0];
        if (!open_n[1]) first_rank[7:4] = data_seen[7:4];
        if (!open_n[2]) first_rank[11:8] = data_seen[11:8];
        // evaluated after the nibbles so a shared enable passes through
        if (!open_n[3]) dac_code = first_rank;
    end
    // dac_code is the converter code: straight or offset binary
endmodule

// >>> verification/dacl_host_props.sv
// pin checks for the dac latch host controller
module dacl_host_props (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic req_valid,
    input wire logic req_ready,
    input wire logic req_done,
    input wire logic chip_select_n,
    input wire logic low_nibble_strobe_n,
    input wire logic mid_nibble_strobe_n,
    input wire logic high_nibble_strobe_n,
    input wire logic output_rank_load_n,
    input wire logic [11:0] data_word_in
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);
    logic any_low;
    // any latch strobe asserted
    assign any_low = !(low_nibble_strobe_n & mid_nibble_strobe_n
        & high_nibble_strobe_n & output_rank_load_n);
    // a strobe is useless without select, so never lead with it
    a_strobe_needs_select: assert property (any_low |-> !chip_select_n)
        else $error("strobe low without select");
    a_select_two_cycles: assert property ($fell(chip_select_n) |=> !chip_select_n ##1 chip_select_n)
        else $error("select low width wrong");
    a_data_stable_sel: assert property (!chip_select_n |-> $stable(data_word_in))
        else $error("data moved while selected");
    a_data_hold_after: assert property ($rose(chip_select_n) |-> $stable(data_word_in))
        else $error("data moved at select release");
    a_done_when_idle: assert property (req_done |-> chip_select_n && !any_low)
        else $error("done while pins active");
    a_rank_with_high: assert property (!output_rank_load_n |-> !high_nibble_strobe_n)
        else $error("rank load without high nibble");
    // lanes a write does not use sit at zero, so nothing stray is latched
    a_upper_lanes_zero: assert property (!chip_select_n && mid_nibble_strobe_n && high_nibble_strobe_n |-> data_word_in[11:4] == 8'h00)
        else $error("upper lanes driven on low nibble write");
    a_lower_lanes_zero: assert property (!chip_select_n && low_nibble_strobe_n && mid_nibble_strobe_n |-> data_word_in[7:0] == 8'h00)
        else $error("lower lanes driven on high nibble write");
    a_done_one_pulse: assert property (req_done |=> !req_done)
        else $error("done longer than one cycle");
    a_done_in_bound: assert property ($rose(req_valid) && req_ready |-> ##[4:30] req_done)
        else $error("request never completed");
    c_wide_write: cover property (!chip_select_n && !low_nibble_strobe_n && !output_rank_load_n);
    c_split_load: cover property (!output_rank_load_n && low_nibble_strobe_n);
    c_done: cover property (req_done);
endmodule
bind dacl_host dacl_host_props u_props (.clk_sys, .rst_n, .req_valid, .req_ready, .req_done,
    .chip_select_n, .low_nibble_strobe_n, .mid_nibble_strobe_n, .high_nibble_strobe_n,
    .output_rank_load_n, .data_word_in);

// >>> verification/test_dacl_host.sv
// self-checking bench for the dac latch host controller
module test_dacl_host;
    timeunit 1ns;
    timeprecision 1ns;
    import dacl_pkg::*;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    dacl_mode_type mode = DACL_MODE_WIDE;
    dacl_code_type coding = DACL_CODE_BINARY;
    logic req_valid = 1'b0;
    logic [11:0] req_word = 12'h000;
    logic req_ready, req_done, chip_select_n, low_nibble_strobe_n, mid_nibble_strobe_n;
    logic high_nibble_strobe_n, output_rank_load_n;
    logic [11:0] data_word_in, first_rank, dac_code;
    int errors = 0;
    int num_checks = 0;
    int cycles = 0;
    always #25 clk_sys = ~clk_sys;
    dacl_host dut (.clk_sys, .rst_n, .mode, .coding, .req_valid, .req_word, .req_ready,
        .req_done, .chip_select_n, .low_nibble_strobe_n, .mid_nibble_strobe_n,
        .high_nibble_strobe_n, .output_rank_load_n, .data_word_in);
    dacl_device_model model (.chip_select_n, .low_nibble_strobe_n, .mid_nibble_strobe_n,
        .high_nibble_strobe_n, .output_rank_load_n, .data_word_in, .first_rank, .dac_code);
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // fourteen writes of under 20 cycles each run far below this; reaching it means a hang
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 3000) begin
            errors++;
            report_and_stop;
        end
    end
    task automatic check(input logic [11:0] seen, input logic [11:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one request; dac may show only old or final code; poke>0 pokes a second request with ~w while busy
    task automatic do_write(input dacl_mode_type m, input dacl_code_type c,
        input logic [11:0] w, input logic [11:0] e, input int poke);
        logic [11:0] old;
        int n;
        old = dac_code;
        n = 0;
        @(negedge clk_sys);
        check({11'h000, req_ready}, 12'h001); // idle and nothing pending
        mode = m;
        coding = c;
        req_word = w;
        req_valid = 1'b1;
        do begin
            @(negedge clk_sys);
            n++;
            req_valid = (n == poke);
            if (n == poke) req_word = ~w;
            if (n == 1) check({11'h000, req_ready}, 12'h000);
            if (dac_code !== old && dac_code !== e) check(dac_code, e);
        end while (req_done !== 1'b1 && n < 60);
        check({11'h000, req_done}, 12'h001);
        check(dac_code, e);
    endtask
    task automatic test_wide;
        do_write(DACL_MODE_WIDE, DACL_CODE_BINARY, 12'hA5C, 12'hA5C, 0);
        check(first_rank, 12'hA5C);
        $display("test wide finished");
    endtask
    task automatic test_split;
        do_write(DACL_MODE_NIBBLE, DACL_CODE_BINARY, 12'h3E7, 12'h3E7, 0);
        do_write(DACL_MODE_LEFT_BYTE, DACL_CODE_BINARY, 12'hFFF, 12'hFFF, 0);
        do_write(DACL_MODE_RIGHT_BYTE, DACL_CODE_BINARY, 12'h800, 12'h800, 0);
        do_write(DACL_MODE_RIGHT_BYTE, DACL_CODE_BINARY, 12'h001, 12'h001, 0);
        do_write(DACL_MODE_LEFT_BYTE, DACL_CODE_BINARY, 12'h000, 12'h000, 0);
        $display("test split finished");
    endtask
    // every mode with twos complement: only the top bit flips
    task automatic test_twos;
        logic [11:0] w;
        for (int i = 0; i < 4; i++) begin
            w = 12'h4A5 + 12'(i << 8);
            do_write(dacl_mode_type'(i), DACL_CODE_TWOS, w, w ^ 12'h800, 0);
        end
        do_write(DACL_MODE_WIDE, DACL_CODE_TWOS, 12'h000, 12'h800, 0);
        do_write(DACL_MODE_RIGHT_BYTE, DACL_CODE_TWOS, 12'h800, 12'h000, 0);
        $display("test twos finished");
    endtask
    // a request while busy is ignored and the output then holds
    task automatic test_refused;
        do_write(DACL_MODE_WIDE, DACL_CODE_BINARY, 12'h0F0, 12'h0F0, 3);
        repeat (10) @(negedge clk_sys);
        check(dac_code, 12'h0F0);
        do_write(DACL_MODE_NIBBLE, DACL_CODE_BINARY, 12'hC3A, 12'hC3A, 2);
        $display("test refused finished");
    endtask
    initial begin
        repeat (8) @(negedge clk_sys);
        rst_n = 1'b1;
        @(negedge clk_sys);
        test_wide;
        test_split;
        test_twos;
        test_refused;
        report_and_stop;
    end
endmodule
